//--- inc/cit_pkg.sv
// Shared constants, opcodes and state type for the instruction timing core.
package cit_pkg;

    // ---------------------------------------------------------------
    // Reset values and sequencing counts
    // ---------------------------------------------------------------
    localparam logic [15:0] CIT_PC_RESET = 16'h0000;
    localparam logic [3:0] CIT_CNT_FIRST = 4'h1;
    localparam logic [3:0] CIT_CNT_OPND1 = 4'h2;
    localparam logic [3:0] CIT_CNT_XACC = 4'h2;
    localparam logic [3:0] CIT_CNT_CODE_SPACE_READ_RD = 4'h2;
    localparam logic [3:0] CIT_CNT_CODE_SPACE_READ_DATA = 4'h3;
    localparam logic [3:0] CIT_CYC_MAX = 4'h8;
    localparam logic [3:0] CIT_CYC_MUL = 4'h4;
    localparam logic [3:0] CIT_CYC_DIV = 4'h8;
    localparam logic [3:0] CIT_CYC_ONE = 4'h1;
    localparam logic [3:0] CIT_CYC_THREE = 4'h3;
    localparam logic [3:0] CIT_TAKEN_EXTRA = 4'h1;

    // ---------------------------------------------------------------
    // Control-flow kinds produced by the decoder
    // ---------------------------------------------------------------
    localparam logic [2:0] CIT_K_SEQ = 3'h0;
    localparam logic [2:0] CIT_K_RCOND = 3'h1;
    localparam logic [2:0] CIT_K_RJMP = 3'h2;
    localparam logic [2:0] CIT_K_ABS11 = 3'h3;
    localparam logic [2:0] CIT_K_ABS16 = 3'h4;
    localparam logic [2:0] CIT_K_EXT = 3'h5;

    // ---------------------------------------------------------------
    // Opcodes watched by the checks
    // ---------------------------------------------------------------
    localparam logic [7:0] CIT_OP_MUL = 8'ha4;
    localparam logic [7:0] CIT_OP_DIV = 8'h84;
    localparam logic [7:0] CIT_OP_SPARE = 8'ha5;
    localparam logic [7:0] CIT_OP_ORL_DI = 8'h43;
    localparam logic [7:0] CIT_OP_ANL_DI = 8'h53;
    localparam logic [7:0] CIT_OP_XRL_DI = 8'h63;
    localparam logic [7:0] CIT_OP_CLR_A = 8'he4;
    localparam logic [7:0] CIT_OP_SWAP_A = 8'hc4;
    localparam logic [7:0] CIT_OP_XRD_PTR = 8'he0;
    localparam logic [7:0] CIT_OP_XWR_PTR = 8'hf0;

    typedef enum logic [1:0] {
        CIT_ST_RUN = 2'b01,
        CIT_ST_HALT = 2'b10
    } cit_state_t;

endpackage

//--- design/cit_decode.sv
// Opcode table: length, base cycle count and control-flow kind of each opcode.
`timescale 1ns/1ps
`default_nettype none
module cit_decode (
    input wire logic [7:0] opcode,
    output logic [1:0] len,
    output logic [3:0] cyc,
    output logic [2:0] kind,
    output logic xmove,
    output logic xwrite,
    output logic code_read
);
    // Table entries are {bytes, cycles} written as two hex digits; a
    // conditional branch carries its not-taken count.
    logic [5:0] lc;
    logic [3:0] lo;
    logic [3:0] hi;

    always_comb begin
        lo = opcode[3:0];
        hi = opcode[7:4];
        lc = 6'h11;
        kind = cit_pkg::CIT_K_SEQ;
        xmove = 1'b0;
        code_read = 1'b0;
        if (lo >= 4'h8) begin
            case (hi)
                4'h7, 4'h8, 4'ha: lc = 6'h22;
                4'hb: begin lc = 6'h33; kind = cit_pkg::CIT_K_RCOND; end
                4'hd: begin lc = 6'h22; kind = cit_pkg::CIT_K_RCOND; end
                default: lc = 6'h11;
            endcase
        end else begin
            case (lo)
                4'h0: begin
                    case (hi)
                        4'h0: lc = 6'h11;
                        4'h1, 4'h2, 4'h3: begin lc = 6'h33; kind = cit_pkg::CIT_K_RCOND; end
                        4'h4, 4'h5, 4'h6, 4'h7: begin lc = 6'h22; kind = cit_pkg::CIT_K_RCOND; end
                        4'h8: begin lc = 6'h23; kind = cit_pkg::CIT_K_RJMP; end
                        4'h9: lc = 6'h33;
                        4'he, 4'hf: begin lc = 6'h13; xmove = 1'b1; end
                        default: lc = 6'h22;
                    endcase
                end
                4'h1: begin lc = 6'h23; kind = cit_pkg::CIT_K_ABS11; end
                4'h2: begin
                    case (hi)
                        4'h0, 4'h1: begin lc = 6'h34; kind = cit_pkg::CIT_K_ABS16; end
                        4'h2, 4'h3: begin lc = 6'h15; kind = cit_pkg::CIT_K_EXT; end
                        4'he, 4'hf: begin lc = 6'h13; xmove = 1'b1; end
                        default: lc = 6'h22;
                    endcase
                end
                4'h3: begin
                    case (hi)
                        4'h4, 4'h5, 4'h6: lc = 6'h33;
                        4'h7: begin lc = 6'h13; kind = cit_pkg::CIT_K_EXT; end
                        4'h8, 4'h9: begin lc = 6'h13; code_read = 1'b1; end
                        4'he, 4'hf: begin lc = 6'h13; xmove = 1'b1; end
                        default: lc = 6'h11;
                    endcase
                end
                4'h4: begin
                    case (hi)
                        4'h8: lc = 6'h18;
                        4'ha: lc = 6'h14;
                        4'hb: begin lc = 6'h33; kind = cit_pkg::CIT_K_RCOND; end
                        4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: lc = 6'h22;
                        default: lc = 6'h11;
                    endcase
                end
                4'h5: begin
                    case (hi)
                        4'h7, 4'h8: lc = 6'h33;
                        4'ha: lc = 6'h11;
                        4'hb, 4'hd: begin lc = 6'h33; kind = cit_pkg::CIT_K_RCOND; end
                        default: lc = 6'h22;
                    endcase
                end
                default: begin
                    case (hi)
                        4'h7, 4'h8, 4'ha: lc = 6'h22;
                        4'hb: begin lc = 6'h34; kind = cit_pkg::CIT_K_RCOND; end
                        default: lc = 6'h12;
                    endcase
                end
            endcase
        end
        len = lc[5:4];
        cyc = lc[3:0];
        xwrite = xmove && (hi == 4'hf);
    end

endmodule // cit_decode
`default_nettype wire

//--- design/cit_core.sv
// Instruction sequencer: fetch, cycle timing, branches, external moves and debug.
//
// How it works
// - Decode opcodes exactly as the classic set.
// - All timing counted in single system clocks.
// - Mostly one clock per instruction byte.
// - Untaken conditional branch is one clock shorter.
// - Max eight clocks; multiply four, divide eight.
// - Accumulator operand timings by addressing mode.
// - Logic immediate into direct byte: three clocks.
// - Direct-to-direct three; indirect store two clocks.
// - Accumulator-only operations: one byte, one clock.
// - Exactly 109 instructions in documented timing classes.
// - Clock up to 25 MHz, one to eight clocks per instruction.
// - External write reaches RAM or program memory.
// - Code memory readable and writable bytewise.
// - Debug: breakpoints, run, halt, step, no resources.
// - Relative target: next address plus signed byte.
// - Spare opcode behaves as no-operation.
// - External moves: one byte, three clocks.
`timescale 1ns/1ps
`default_nettype none
module cit_core (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] code_data,
    input wire logic branch_cond,
    input wire logic [15:0] ext_target,
    input wire logic [15:0] code_space_read_addr,
    input wire logic pgm_wr_en,
    input wire logic irq_req,
    input wire logic [15:0] irq_vec,
    input wire logic dbg_halt,
    input wire logic dbg_run,
    input wire logic dbg_step,
    input wire logic bkpt_en,
    input wire logic [15:0] bkpt_addr,
    input wire logic dbg_pc_wr,
    input wire logic [15:0] dbg_pc,
    output logic [15:0] code_addr_q,
    output logic code_rd_q,
    output logic [15:0] pc_q,
    output logic insn_done_q,
    output logic [7:0] insn_opcode_q,
    output logic [3:0] insn_cycles_q,
    output logic taken_q,
    output logic xdata_rd_q,
    output logic xdata_wr_q,
    output logic code_wr_q,
    output logic [7:0] code_space_read_data_q,
    output logic code_space_read_valid_q,
    output logic irq_ack_q,
    output logic halted_q
);

    // ---------------------------------------------------------------
    // Decode of the opcode byte
    // ---------------------------------------------------------------
    cit_pkg::cit_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] op_q;
    logic [1:0] len_q;
    logic [3:0] cyc_q;
    logic [2:0] kind_q;
    logic xm_q;
    logic xw_q;
    logic mc_q;
    logic [7:0] b1_q;
    logic [15:0] tgt_q;
    logic tk_pend_q;
    logic step_q;
    logic [3:0] done_base_q;
    logic [1:0] d_len;
    logic [3:0] d_cyc;
    logic [2:0] d_kind;
    logic d_xm;
    logic d_xw;
    logic d_mc;

    cit_decode u_decode (
        .opcode(code_data),
        .len(d_len),
        .cyc(d_cyc),
        .kind(d_kind),
        .xmove(d_xm),
        .xwrite(d_xw),
        .code_read(d_mc)
    );

    function automatic logic [15:0] cit_rel(input logic [15:0] base, input logic [7:0] disp);
        cit_rel = base + {{8{disp[7]}}, disp};
    endfunction

    // ---------------------------------------------------------------
    // Cycle decisions
    // ---------------------------------------------------------------
    logic run;
    logic first;
    logic [7:0] op;
    logic [1:0] cur_len;
    logic [3:0] cur_cyc;
    logic [2:0] cur_kind;
    logic cond_hit;
    logic last;
    logic redirect;
    logic stop;
    logic [15:0] seq_pc;
    logic [15:0] tgt_now;
    logic [15:0] next_pc;
    logic [15:0] pc_after;
    logic [15:0] fetch_addr;
    logic fetch_rd;

    always_comb begin
        run = (state_q == cit_pkg::CIT_ST_RUN);
        first = (cnt_q == cit_pkg::CIT_CNT_FIRST);
        op = first ? code_data : op_q;
        cur_len = first ? d_len : len_q;
        cur_cyc = first ? d_cyc : cyc_q;
        cur_kind = first ? d_kind : kind_q;
        seq_pc = pc_q + {14'h0000, cur_len};
        // The condition is judged in the not-taken last clock; a true
        // condition buys exactly one more clock to fetch the target.
        cond_hit = (cur_kind == cit_pkg::CIT_K_RCOND) && (cnt_q == cur_cyc) && branch_cond && !tk_pend_q;
        last = tk_pend_q || ((cnt_q == cur_cyc) && !cond_hit);
        redirect = tk_pend_q || (cur_kind == cit_pkg::CIT_K_RJMP) || (cur_kind == cit_pkg::CIT_K_ABS11)
            || (cur_kind == cit_pkg::CIT_K_ABS16) || (cur_kind == cit_pkg::CIT_K_EXT);
        case (cur_kind)
            cit_pkg::CIT_K_ABS11: tgt_now = {seq_pc[15:11], op[7:5], code_data};
            cit_pkg::CIT_K_ABS16: tgt_now = {b1_q, code_data};
            default: tgt_now = cit_rel(seq_pc, code_data);
        endcase
        if (!redirect) begin
            next_pc = seq_pc;
        end else if (cur_kind == cit_pkg::CIT_K_EXT) begin
            next_pc = ext_target;
        end else begin
            next_pc = tgt_q;
        end
        pc_after = irq_req ? irq_vec : next_pc;
        stop = dbg_halt || step_q || (bkpt_en && (pc_after == bkpt_addr));
        fetch_rd = 1'b0;
        fetch_addr = code_addr_q;
        if (run) begin
            if (last) begin
                fetch_rd = !stop;
                fetch_addr = pc_after;
            end else if (cnt_q < {2'b00, cur_len}) begin
                fetch_rd = 1'b1;
                fetch_addr = pc_q + {12'h000, cnt_q};
            end else if (mc_q && (cnt_q == cit_pkg::CIT_CNT_CODE_SPACE_READ_RD)) begin
                fetch_rd = 1'b1;
                fetch_addr = code_space_read_addr;
            end
        end else if (dbg_run || dbg_step) begin
            fetch_rd = 1'b1;
            fetch_addr = dbg_pc_wr ? dbg_pc : pc_q;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer state
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= cit_pkg::CIT_ST_RUN;
            cnt_q <= cit_pkg::CIT_CNT_FIRST;
            pc_q <= cit_pkg::CIT_PC_RESET;
            op_q <= 8'h00;
            len_q <= 2'h0;
            cyc_q <= 4'h0;
            kind_q <= cit_pkg::CIT_K_SEQ;
            xm_q <= 1'b0;
            xw_q <= 1'b0;
            mc_q <= 1'b0;
            b1_q <= 8'h00;
            tgt_q <= cit_pkg::CIT_PC_RESET;
            tk_pend_q <= 1'b0;
            step_q <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                cit_pkg::CIT_ST_RUN: begin
                    if (first) begin
                        op_q <= code_data;
                        len_q <= d_len;
                        cyc_q <= d_cyc;
                        kind_q <= d_kind;
                        xm_q <= d_xm;
                        xw_q <= d_xw;
                        mc_q <= d_mc;
                    end
                    if (cnt_q == cit_pkg::CIT_CNT_OPND1) begin
                        b1_q <= code_data;
                    end
                    if (!first && (cnt_q == {2'b00, cur_len})) begin
                        tgt_q <= tgt_now;
                    end
                    if (last) begin
                        pc_q <= pc_after;
                        cnt_q <= cit_pkg::CIT_CNT_FIRST;
                        tk_pend_q <= 1'b0;
                        if (stop) begin
                            state_q <= cit_pkg::CIT_ST_HALT;
                            step_q <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                        tk_pend_q <= cond_hit;
                    end
                end
                cit_pkg::CIT_ST_HALT: begin
                    // Halting only stops fetch; no user memory or stack is touched.
                    if (dbg_pc_wr) begin
                        pc_q <= dbg_pc;
                    end
                    if (dbg_run || dbg_step) begin
                        state_q <= cit_pkg::CIT_ST_RUN;
                        cnt_q <= cit_pkg::CIT_CNT_FIRST;
                        step_q <= dbg_step;
                    end
                end
                default: state_q <= cit_pkg::CIT_ST_HALT;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Code fetch port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            code_addr_q <= cit_pkg::CIT_PC_RESET;
            code_rd_q <= 1'b1;
        end else if (clk_en) begin
            code_addr_q <= fetch_addr;
            code_rd_q <= fetch_rd;
        end
    end

    // ---------------------------------------------------------------
    // Completion and debug status
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            insn_done_q <= 1'b0;
            insn_opcode_q <= 8'h00;
            insn_cycles_q <= 4'h0;
            taken_q <= 1'b0;
            irq_ack_q <= 1'b0;
            halted_q <= 1'b0;
            done_base_q <= 4'h0;
        end else if (clk_en) begin
            insn_done_q <= run && last;
            irq_ack_q <= run && last && irq_req;
            halted_q <= run ? (last && stop) : !(dbg_run || dbg_step);
            if (run && last) begin
                insn_opcode_q <= op;
                insn_cycles_q <= cnt_q;
                taken_q <= tk_pend_q;
                done_base_q <= cur_cyc;
            end
        end
    end

    // ---------------------------------------------------------------
    // External-space moves and code reads
    // ---------------------------------------------------------------
    // A write with program store enabled goes to program memory instead of RAM.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            xdata_rd_q <= 1'b0;
            xdata_wr_q <= 1'b0;
            code_wr_q <= 1'b0;
            code_space_read_valid_q <= 1'b0;
            code_space_read_data_q <= 8'h00;
        end else if (clk_en) begin
            xdata_rd_q <= run && xm_q && !xw_q && (cnt_q == cit_pkg::CIT_CNT_XACC);
            xdata_wr_q <= run && xw_q && !pgm_wr_en && (cnt_q == cit_pkg::CIT_CNT_XACC);
            code_wr_q <= run && xw_q && pgm_wr_en && (cnt_q == cit_pkg::CIT_CNT_XACC);
            code_space_read_valid_q <= run && mc_q && (cnt_q == cit_pkg::CIT_CNT_CODE_SPACE_READ_DATA);
            if (run && mc_q && (cnt_q == cit_pkg::CIT_CNT_CODE_SPACE_READ_DATA)) begin
                code_space_read_data_q <= code_data;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    cycle_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q |-> (insn_cycles_q >= cit_pkg::CIT_CYC_ONE) && (insn_cycles_q <= cit_pkg::CIT_CYC_MAX))
        else $error("instruction exceeded eight clocks");
    mul_timing_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && (insn_opcode_q == cit_pkg::CIT_OP_MUL) |-> insn_cycles_q == cit_pkg::CIT_CYC_MUL)
        else $error("multiply not four clocks");
    div_timing_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && (insn_opcode_q == cit_pkg::CIT_OP_DIV) |-> insn_cycles_q == cit_pkg::CIT_CYC_DIV)
        else $error("divide not eight clocks");
    taken_extra_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && taken_q |-> insn_cycles_q == done_base_q + cit_pkg::CIT_TAKEN_EXTRA)
        else $error("taken branch not one clock longer");
    untaken_base_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && !taken_q |-> insn_cycles_q == done_base_q)
        else $error("instruction ran past its base count");
    logic_imm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && ((insn_opcode_q == cit_pkg::CIT_OP_ORL_DI) || (insn_opcode_q == cit_pkg::CIT_OP_ANL_DI)
        || (insn_opcode_q == cit_pkg::CIT_OP_XRL_DI)) |-> insn_cycles_q == cit_pkg::CIT_CYC_THREE)
        else $error("logic immediate to direct not three clocks");
    acc_only_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && ((insn_opcode_q == cit_pkg::CIT_OP_CLR_A) || (insn_opcode_q == cit_pkg::CIT_OP_SWAP_A))
        |-> insn_cycles_q == cit_pkg::CIT_CYC_ONE)
        else $error("accumulator operation not one clock");
    spare_nop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && (insn_opcode_q == cit_pkg::CIT_OP_SPARE) |-> insn_cycles_q == cit_pkg::CIT_CYC_ONE)
        else $error("spare opcode not a one clock no-op");
    xmove_three_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        insn_done_q && ((insn_opcode_q == cit_pkg::CIT_OP_XRD_PTR) || (insn_opcode_q == cit_pkg::CIT_OP_XWR_PTR))
        |-> insn_cycles_q == cit_pkg::CIT_CYC_THREE)
        else $error("external move not three clocks");
    halt_fetch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        halted_q && clk_en && !dbg_run && !dbg_step |=> halted_q && !code_rd_q)
        else $error("fetch while halted");
    step_resume_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        halted_q && clk_en && dbg_step |=> !halted_q && code_rd_q)
        else $error("step did not resume fetch");

endmodule // cit_core
`default_nettype wire

//--- dv/cit_pmem.sv
// Program memory model answering the core's code fetch port in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module cit_pmem (
    input wire logic clk_sys,
    input wire logic [15:0] code_addr,
    input wire logic code_rd,
    output logic [7:0] code_data
);
    logic [7:0] mem [0:255];
    logic [7:0] last_q = 8'h00;

    // An unselected read port shows the inverse of its last byte so that a
    // fetch taken while the strobe is low cannot pass by luck.
    always_ff @(posedge clk_sys) begin
        if (code_rd) begin
            last_q <= code_data;
        end
    end

    always_comb begin
        code_data = code_rd ? mem[code_addr[7:0]] : ~last_q;
    end
endmodule // cit_pmem
`default_nettype wire

//--- dv/cit_core_tb.sv
// Self-checking testbench for the instruction timing core.
`timescale 1ns/1ps
`default_nettype none
module cit_core_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic branch_cond = 1'b0;
    logic pgm_wr_en = 1'b1;
    logic dbg_halt = 1'b0;
    logic dbg_run = 1'b0;
    logic dbg_step = 1'b0;
    logic bkpt_en = 1'b0;
    logic [15:0] bkpt_addr = 16'h0000;
    logic dbg_pc_wr = 1'b0;
    logic [15:0] dbg_pc = 16'h0000;
    logic [7:0] code_data;
    logic [15:0] code_addr_q;
    logic code_rd_q, insn_done_q, taken_q, xdata_rd_q, xdata_wr_q, code_wr_q, halted_q;
    logic [7:0] insn_opcode_q;
    logic [3:0] insn_cycles_q;
    logic [15:0] pc_q;
    logic [7:0] code_space_read_data_q;
    logic code_space_read_valid_q;
    logic [15:0] code_space_read_addr = 16'h0009;
    logic [12:0] exp_q [$];
    int n_fail = 0;
    int checks = 0;
    int n_xrd = 0;
    int n_xwr = 0;
    int n_cwr = 0;
    int n_mc = 0;
    integer seed = 32'h6ef199f8;

    always #10 clk_sys = ~clk_sys;

    cit_pmem i_cit_pmem (.clk_sys(clk_sys), .code_addr(code_addr_q), .code_rd(code_rd_q), .code_data(code_data));

    cit_core i_cit_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .code_data(code_data),
        .branch_cond(branch_cond), .ext_target(16'h0000), .code_space_read_addr(code_space_read_addr), .pgm_wr_en(pgm_wr_en),
        .irq_req(1'b0), .irq_vec(16'h0000), .dbg_halt(dbg_halt), .dbg_run(dbg_run), .dbg_step(dbg_step),
        .bkpt_en(bkpt_en), .bkpt_addr(bkpt_addr), .dbg_pc_wr(dbg_pc_wr), .dbg_pc(dbg_pc),
        .code_addr_q(code_addr_q), .code_rd_q(code_rd_q), .pc_q(pc_q), .insn_done_q(insn_done_q),
        .insn_opcode_q(insn_opcode_q), .insn_cycles_q(insn_cycles_q), .taken_q(taken_q),
        .xdata_rd_q(xdata_rd_q), .xdata_wr_q(xdata_wr_q), .code_wr_q(code_wr_q), .code_space_read_data_q(code_space_read_data_q),
        .code_space_read_valid_q(code_space_read_valid_q), .irq_ack_q(), .halted_q(halted_q));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Lay down one instruction; operand bytes other than branch offsets are random.
    task automatic put(inout int a, input logic [7:0] op, input int nb, input logic [3:0] cyc, input logic tk);
        i_cit_pmem.mem[a] = op;
        for (int k = 1; k < nb; k++) begin
            i_cit_pmem.mem[a + k] = 8'($random(seed));
        end
        exp_q.push_back({op, cyc, tk});
        a += nb;
    endtask

    task automatic wait_halt(input logic lvl);
        int n;
        n = 0;
        while (halted_q !== lvl && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check({15'h0000, halted_q}, {15'h0000, lvl});
    endtask

    // Results are compared in arrival order against the notes queued by the driver.
    always @(posedge clk_sys) begin
        if (insn_done_q === 1'b1 && exp_q.size() > 0) begin
            check({3'h0, insn_opcode_q, insn_cycles_q, taken_q}, {3'h0, exp_q.pop_front()});
            if (insn_opcode_q === 8'h40) begin
                branch_cond <= 1'b1;
            end
            // The second external write of the program goes to RAM.
            if (insn_opcode_q === cit_pkg::CIT_OP_XWR_PTR) begin
                pgm_wr_en <= 1'b0;
            end
        end
        if (code_space_read_valid_q === 1'b1) begin
            check({8'h00, code_space_read_data_q}, {8'h00, i_cit_pmem.mem[code_space_read_addr[7:0]]});
        end
        n_mc += (code_space_read_valid_q === 1'b1);
        n_xrd += (xdata_rd_q === 1'b1);
        n_xwr += (xdata_wr_q === 1'b1);
        n_cwr += (code_wr_q === 1'b1);
    end

    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        int a;
        // Unused memory holds the divide opcode, so a wrong target shows as a wrong opcode.
        for (int k = 0; k < 256; k++) begin
            i_cit_pmem.mem[k] = cit_pkg::CIT_OP_DIV;
        end
        a = 0;
        put(a, cit_pkg::CIT_OP_CLR_A, 1, 4'h1, 1'b0);
        put(a, cit_pkg::CIT_OP_SWAP_A, 1, 4'h1, 1'b0);
        put(a, cit_pkg::CIT_OP_SPARE, 1, 4'h1, 1'b0);
        put(a, 8'h28, 1, 4'h1, 1'b0);
        put(a, 8'h24, 2, 4'h2, 1'b0);
        put(a, 8'h26, 1, 4'h2, 1'b0);
        put(a, 8'ha3, 1, 4'h1, 1'b0);
        put(a, cit_pkg::CIT_OP_ORL_DI, 3, 4'h3, 1'b0);
        put(a, cit_pkg::CIT_OP_ANL_DI, 3, 4'h3, 1'b0);
        put(a, cit_pkg::CIT_OP_XRL_DI, 3, 4'h3, 1'b0);
        put(a, 8'h85, 3, 4'h3, 1'b0);
        put(a, 8'hf6, 1, 4'h2, 1'b0);
        put(a, cit_pkg::CIT_OP_MUL, 1, 4'h4, 1'b0);
        put(a, cit_pkg::CIT_OP_DIV, 1, 4'h8, 1'b0);
        put(a, cit_pkg::CIT_OP_XRD_PTR, 1, 4'h3, 1'b0);
        put(a, cit_pkg::CIT_OP_XWR_PTR, 1, 4'h3, 1'b0);
        put(a, cit_pkg::CIT_OP_XWR_PTR, 1, 4'h3, 1'b0);
        put(a, 8'h83, 1, 4'h3, 1'b0);
        put(a, 8'h40, 1, 4'h2, 1'b0);
        i_cit_pmem.mem[a] = 8'h05;
        a++;
        put(a, 8'h40, 1, 4'h3, 1'b1);
        i_cit_pmem.mem[a] = 8'h10;
        a = a + 1 + 16;
        put(a, 8'h00, 1, 4'h1, 1'b0);
        i_cit_pmem.mem[a] = 8'h80;
        i_cit_pmem.mem[a + 1] = 8'hfe;
        repeat (12) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        repeat (80) @(posedge clk_sys);
        #1;
        check(16'(exp_q.size()), 16'h0000);
        check({n_xrd[3:0], n_xwr[3:0], n_cwr[3:0], n_mc[3:0]}, 16'h1111);
        dbg_halt = 1'b1;
        wait_halt(1'b1);
        dbg_step = 1'b1;
        @(posedge clk_sys);
        #1;
        dbg_step = 1'b0;
        // Noted only now, so the result of the instruction that halted is not taken for it.
        exp_q.push_back({8'h80, 4'h3, 1'b0});
        wait_halt(1'b1);
        @(posedge clk_sys);
        #1;
        check(16'(exp_q.size()), 16'h0000);
        check(pc_q, 16'h0030);
        dbg_halt = 1'b0;
        bkpt_en = 1'b1;
        bkpt_addr = 16'h0030;
        dbg_pc = 16'h002f;
        dbg_pc_wr = 1'b1;
        dbg_run = 1'b1;
        exp_q.push_back({8'h00, 4'h1, 1'b0});
        @(posedge clk_sys);
        #1;
        dbg_pc_wr = 1'b0;
        dbg_run = 1'b0;
        wait_halt(1'b0);
        repeat (2) @(posedge clk_sys);
        #1;
        wait_halt(1'b1);
        check(16'(exp_q.size()), 16'h0000);
        check(pc_q, bkpt_addr);
        // A reset while halted must leave halt and restart at the reset address.
        sys_rst = 1'b1;
        exp_q.push_back({cit_pkg::CIT_OP_CLR_A, 4'h1, 1'b0});
        repeat (2) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(16'(exp_q.size()), 16'h0000);
        check({15'h0000, halted_q}, 16'h0000);
        tally_and_finish();
    end
endmodule // cit_core_tb
`default_nettype wire
